// ---- core/rbwop_pkg.sv ----
// Package: constants and types shared by the byte-write memory block
package rbwop_pkg;

   // ************************************************************
   // Port width modes
   // ************************************************************
   localparam logic [2:0] RBWOP_W1 = 3'h0;
   localparam logic [2:0] RBWOP_W2 = 3'h1;
   localparam logic [2:0] RBWOP_W4 = 3'h2;
   localparam logic [2:0] RBWOP_W9 = 3'h3;
   localparam logic [2:0] RBWOP_W18 = 3'h4;
   localparam logic [2:0] RBWOP_W36 = 3'h5;
   localparam logic [2:0] RBWOP_W72 = 3'h6;

   // ************************************************************
   // Array geometry (72-bit word: 64 data + 8 parity)
   // ************************************************************
   localparam int RBWOP_LANES = 8;
   localparam int RBWOP_DATA_W = 64;
   localparam int RBWOP_ADDR_W = 9;
   localparam int RBWOP_DEPTH = 512;
   localparam int RBWOP_BYTE_W = 8;

   // Reset values of pipeline state
   localparam logic [71:0] RBWOP_RESET_WORD = 72'h00_0000_0000_0000_0000;
   localparam logic [RBWOP_ADDR_W-1:0] RBWOP_RESET_ADDR = 9'h000;

   // Output pipeline state codes, one-hot
   typedef enum logic [1:0] {
      RBWOP_PIPE_IDLE = 2'b01,
      RBWOP_PIPE_FULL = 2'b10
   } rbwop_pipe_t;

endpackage

// ---- core/rbwop_lane_if.sv ----
// Interface: write-enable lanes between mapper and memory core
`timescale 1ns/1ps
interface rbwop_lane_if;
   logic [2:0] widthMode;
   logic [7:0] userWe;
   logic [7:0] laneWe;
   modport mapper (input widthMode, input userWe, output laneWe);
   modport core (output widthMode, output userWe, input laneWe);
endinterface

// ---- core/rbwop_we_map.sv ----
// Module: maps user write enables onto internal byte lanes by port width
`timescale 1ns/1ps
module rbwop_we_map
   import rbwop_pkg::*;
(
   rbwop_lane_if.mapper lanes
);

   // Spread one enable bit over a lane group at x18 and narrower; one bit per lane at x36 and x72
   function automatic logic [7:0] rbwop_map(input logic [2:0] mode,
                                            input logic [7:0] we);
      logic [7:0] res;
      res = 8'h00;
      case (mode)
         RBWOP_W72: res = we;
         RBWOP_W36: res = {4'h0, we[3:0]};
         RBWOP_W18: res = {4'h0, we[1], we[0], we[1], we[0]};
         default: res = {4'h0, {4{we[0]}}};
      endcase
      return res;
   endfunction

   // Lane decode is pure wiring; the core registers its effect
   always_comb begin
      lanes.laneWe = rbwop_map(lanes.widthMode, lanes.userWe);
   end

endmodule // rbwop_we_map

// ---- core/rbwop_ram.sv ----
// Module: byte-write block memory with optional output pipeline register
`timescale 1ns/1ps
module rbwop_ram
   import rbwop_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] widthMode,
   input wire logic useOutputReg,
   input wire logic [71:0] output_preset_value,
   input wire logic portEnable,
   input wire logic [7:0] userWe,
   input wire logic [RBWOP_ADDR_W-1:0] addr,
   input wire logic [71:0] write_data_in,
   input wire logic sync_output_set,
   input wire logic output_reg_clock_enable,
   input wire logic addrSettled,
   output logic [71:0] readData,
   output logic addrFault
);

   // ************************************************************
   // Storage and lane mapping
   // ************************************************************
   logic [71:0] mem [RBWOP_DEPTH];
   rbwop_lane_if lanes ();

   assign lanes.widthMode = widthMode;
   assign lanes.userWe = userWe;

   rbwop_we_map uMap (
      .lanes(lanes)
   );

   // Full-word write mask: lane n covers data byte n and parity bit n
   function automatic logic [71:0] rbwop_mask(input logic [7:0] lw);
      logic [71:0] m;
      m = '0;
      for (int n = 0; n < RBWOP_LANES; n++) begin
         m[n*RBWOP_BYTE_W +: RBWOP_BYTE_W] = {RBWOP_BYTE_W{lw[n]}};
         m[RBWOP_DATA_W + n] = lw[n];
      end
      return m;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [71:0] readLatch;
      logic [71:0] outReg;
      logic [RBWOP_ADDR_W-1:0] lastAddr;
      logic lastEn;
      logic fault;
      logic [71:0] dout;
      rbwop_pipe_t pipe;
   } rbwop_state_t;

   rbwop_state_t st, next_st;
   logic [71:0] wrMask;
   logic [71:0] memWord;
   logic [71:0] newWord;

   assign wrMask = rbwop_mask(lanes.laneWe);
   assign memWord = mem[addr];
   assign newWord = (memWord & ~wrMask) | (write_data_in & wrMask);

   // Array write: gated by port enable and any user write enable, never by set or reg enable
   always_ff @(posedge clk_sys) begin
      if (portEnable && (|userWe)) begin
         mem[addr] <= newWord;
      end
   end

   // Next-state logic for latch, output register and fault monitor
   always_comb begin
      next_st = st;
      // Write-first read into the latch; set touches only outputs
      if (portEnable) begin
         if (sync_output_set && !useOutputReg) begin
            next_st.readLatch = output_preset_value;
         end else begin
            next_st.readLatch = newWord;
         end
      end
      // Output register: own enable, set loads the preset
      if (useOutputReg && output_reg_clock_enable) begin
         if (sync_output_set) begin
            next_st.outReg = output_preset_value;
         end else begin
            next_st.outReg = st.readLatch;
         end
         next_st.pipe = RBWOP_PIPE_FULL;
      end
      // Address move into an enabled write after an enabled cycle, or an unsettled address while enabled, is a fault
      next_st.lastAddr = addr;
      next_st.lastEn = portEnable;
      if (portEnable && (!addrSettled ||
          (st.lastEn && st.lastAddr != addr && |userWe))) begin
         next_st.fault = 1'b1;
      end
      // Output flop follows the stage the mode pin selects
      next_st.dout = useOutputReg ? next_st.outReg : next_st.readLatch;
   end

   // Single state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st.readLatch <= RBWOP_RESET_WORD;
         st.outReg <= RBWOP_RESET_WORD;
         st.lastAddr <= RBWOP_RESET_ADDR;
         st.lastEn <= 1'b0;
         st.fault <= 1'b0;
         st.dout <= RBWOP_RESET_WORD;
         st.pipe <= RBWOP_PIPE_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from flops; no mux after the register
   assign readData = st.dout;
   assign addrFault = st.fault;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_SET_LOADS: assert property (@(posedge clk_sys) disable iff (rst)
      useOutputReg && output_reg_clock_enable && sync_output_set
      |=> st.outReg == $past(output_preset_value))
      else $error("set did not load preset");
   AST_REG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      !output_reg_clock_enable |=> $stable(st.outReg))
      else $error("output register moved without enable");
   AST_PIPE_LAT: assert property (@(posedge clk_sys) disable iff (rst)
      portEnable && !sync_output_set ##1 useOutputReg &&
      output_reg_clock_enable && !sync_output_set
      |=> st.outReg == $past(st.readLatch))
      else $error("pipeline stage lost latch data");
   AST_DISABLED: assert property (@(posedge clk_sys) disable iff (rst)
      !portEnable |=> $stable(st.readLatch))
      else $error("latch changed while disabled");
   AST_X36: assert property (@(posedge clk_sys) disable iff (rst)
      widthMode == RBWOP_W36 |-> lanes.laneWe == {4'h0, userWe[3:0]})
      else $error("x36 lane map wrong");
   AST_X18: assert property (@(posedge clk_sys) disable iff (rst)
      widthMode == RBWOP_W18 |-> lanes.laneWe[2] == userWe[0] &&
      lanes.laneWe[3] == userWe[1])
      else $error("x18 lane map wrong");
   AST_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
      portEnable && !addrSettled |=> addrFault)
      else $error("address fault not flagged");
   AST_X72: assert property (@(posedge clk_sys) disable iff (rst)
      widthMode == RBWOP_W72 |-> lanes.laneWe == userWe)
      else $error("x72 lane map wrong");

endmodule // rbwop_ram

// ---- verification/rbwop_user_model.sv ----
// Partner: user logic that reports whether its address met the window
`timescale 1ns/1ps
module rbwop_user_model (
   input wire logic portEnable,
   input wire logic skew,
   output logic addrSettled
);
   // Address held steady unless a scenario commands a skew while enabled
   assign addrSettled = !(skew && portEnable);
endmodule // rbwop_user_model

// ---- verification/ram_byte_write_output_pipeline_test.sv ----
// Testbench: lane mapping, output register, set, disable and fault
`timescale 1ns/1ps
module ram_byte_write_output_pipeline_test;
   import rbwop_pkg::*;
   localparam logic [71:0] PRE = 72'hA5_0101_C3C3_5A5A_0F0F;
   localparam logic [71:0] DAT = 72'h3C_1234_5678_9ABC_DEF0;
   logic clk_sys = 0, rst = 1, useReg = 0, en = 0, sset = 0, rce = 0;
   logic skew = 0, fault, settled;
   logic [2:0] mode = RBWOP_W72;
   logic [7:0] we = 8'h00;
   logic [8:0] addr = 9'h000;
   logic [71:0] wd = '0, rd;
   int fail_count = 0, checked = 0;

   rbwop_ram u_rbwop_ram (.clk_sys(clk_sys), .rst(rst), .widthMode(mode),
      .useOutputReg(useReg), .output_preset_value(PRE), .portEnable(en),
      .userWe(we), .addr(addr), .write_data_in(wd), .sync_output_set(sset),
      .output_reg_clock_enable(rce), .addrSettled(settled), .readData(rd),
      .addrFault(fault));
   rbwop_user_model u_rbwop_user_model (.portEnable(en), .skew(skew),
      .addrSettled(settled));

   // ****************************************
   // Helpers
   // ****************************************
   initial forever #20 clk_sys = ~clk_sys;

   task automatic cmp(input logic [71:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask

   // One active edge, then idle; outputs are looked at on the falling edge
   task automatic cyc(input logic e, input logic [7:0] w,
         input logic [8:0] a, input logic [71:0] d, input logic s, r);
      @(posedge clk_sys);
      en <= e;
      we <= w;
      addr <= a;
      wd <= d;
      sset <= s;
      rce <= r;
      @(posedge clk_sys);
      en <= 1'b0;
      we <= 8'h00;
      sset <= 1'b0;
      rce <= 1'b0;
      @(negedge clk_sys);
   endtask

   // Expected written bits, worked out from the lane map per width
   function automatic logic [71:0] mask(input logic [2:0] m,
         input logic [7:0] w);
      logic [7:0] l;
      case (m)
         RBWOP_W72: l = w;
         RBWOP_W36: l = {4'h0, w[3:0]};
         RBWOP_W18: l = {4'h0, w[1], w[0], w[1], w[0]};
         default: l = {4'h0, {4{w[0]}}};
      endcase
      mask = '0;
      for (int n = 0; n < 8; n++) begin
         mask[8*n +: 8] = {8{l[n]}};
         mask[64+n] = l[n];
      end
   endfunction

   // ****************************************
   // Scenarios
   // ****************************************
   // Clear the mapped lanes (all at x72, lanes 0-3 otherwise), write ones under a partial enable, read back
   task automatic test_lanes;
      logic [7:0] pats [2] = '{8'h96, 8'h69};
      for (int m = 0; m < 7; m++) begin
         @(posedge clk_sys);
         mode <= 3'(m);
         foreach (pats[i]) begin
            cyc(1, 8'hFF, 9'h011, '0, 0, 0);
            cyc(1, pats[i], 9'h011, '1, 0, 0);
            cyc(1, 8'h00, 9'h011, '0, 0, 0);
            cmp(rd, mask(3'(m), pats[i]), "lane map");
         end
      end
      $display("test_lanes done");
   endtask

   // Register mode: set, hold, extra latency, set beside a read, disable; then latch mode: disable, set
   task automatic test_pipe;
      @(posedge clk_sys);
      useReg <= 1;
      cyc(0, 8'h00, 9'h022, '0, 1, 1);
      cmp(rd, PRE, "set");
      cyc(1, 8'hFF, 9'h022, DAT, 0, 0);
      cmp(rd, PRE, "reg held");
      cyc(0, 8'h00, 9'h022, '0, 0, 1);
      cmp(rd, DAT, "one more cycle");
      cyc(1, 8'h00, 9'h022, '1, 1, 1);
      cmp(rd, PRE, "set over read");
      cyc(0, 8'h00, 9'h022, '0, 0, 1);
      cmp(rd, DAT, "read beside set");
      cyc(0, 8'hFF, 9'h022, '0, 1, 0);
      cmp(rd, DAT, "disabled");
      @(posedge clk_sys);
      useReg <= 0;
      cyc(0, 8'hFF, 9'h022, '0, 1, 0);
      cmp(rd, DAT, "latch disabled");
      cyc(1, 8'h00, 9'h022, '0, 0, 0);
      cmp(rd, DAT, "array kept");
      cyc(1, 8'h00, 9'h022, '1, 1, 0);
      cmp(rd, PRE, "latch set");
      cyc(1, 8'h00, 9'h022, '0, 0, 0);
      cmp(rd, DAT, "set ignores data");
      $display("test_pipe done");
   endtask

   // Address skew while enabled raises a sticky fault
   task automatic test_fault;
      cmp({71'h0, fault}, '0, "no fault yet");
      @(posedge clk_sys);
      skew <= 1;
      cyc(1, 8'h00, 9'h022, '0, 0, 0);
      @(posedge clk_sys);
      skew <= 0;
      cyc(0, 8'h00, 9'h022, '0, 0, 0);
      cyc(0, 8'h00, 9'h022, '0, 0, 0);
      cmp({71'h0, fault}, {71'h0, 1'b1}, "fault");
      $display("test_fault done");
   endtask

   task automatic complete_run;
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Run is about 130 cycles; the watchdog allows far more
   initial begin
      repeat (2000) @(posedge clk_sys);
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 0;
      @(negedge clk_sys);
      cmp(rd, '0, "reset data");
      test_lanes();
      test_pipe();
      test_fault();
      complete_run();
   end
endmodule // ram_byte_write_output_pipeline_test
